// ### rtl/lpdpd_pkg.sv
// package: timing, command and state definitions shared by both ends of the power-down link
package lpdpd_pkg;

  // ****************************************
  // clock and timing figures
  // ****************************************
  localparam int CK_PERIOD_NS = 100;
  localparam int T_CKELCS_NS = 5;
  localparam int T_CKELCK_NS = 5;
  localparam int T_CKE_NS = 8;
  localparam int T_XP_NS = 500;
  localparam int T_CKCKEH_NS = 2;
  localparam int T_CMDCKE_NS = 2;
  localparam int T_MRWCKEL_NS = 14;
  localparam int T_VREF_LONG_NS = 250;
  localparam int T_ZQCKE_NS = 2;
  localparam int T_DQSCK_MAX_NS = 4;
  localparam int T_DQSS_DQS2DQ_NS = 2;
  localparam int T_WR_NS = 18;
  localparam int T_RCD_NS = 18;
  localparam int T_RP_NS = 21;
  localparam int T_RFC_NS = 130;
  localparam int T_ZQCAL_NS = 1000;
  localparam int T_OSC_NS = 800;
  localparam int RL_NCK = 14;
  localparam int WL_NCK = 8;
  localparam int BL = 16;
  localparam int NWR_NCK = 6;
  localparam int RD_POST_SHORT_NCK = 1;
  localparam int RD_POST_LONG_NCK = 2;
  localparam int WRA_EXTRA_NCK = 2;

  // least times round up to whole cycles, never below one
  function automatic int lpdpd_cyc(input int ns);
    int c;
    c = (ns + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ****************************************
  // cycle counts
  // ****************************************
  localparam int TMR_W = 8;
  localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;
  localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;
  localparam logic [TMR_W-1:0] CKELCK_CYC =
    TMR_W'((T_CKELCK_NS > T_CKELCS_NS) ? lpdpd_cyc(T_CKELCK_NS) : lpdpd_cyc(T_CKELCS_NS));
  localparam logic [TMR_W-1:0] CKE_MIN_CYC = TMR_W'(lpdpd_cyc(T_CKE_NS));
  localparam logic [TMR_W-1:0] XP_CYC = TMR_W'(lpdpd_cyc(T_XP_NS));
  localparam logic [TMR_W-1:0] CKCKEH_CYC = TMR_W'(lpdpd_cyc(T_CKCKEH_NS));
  localparam logic [TMR_W-1:0] CMDCKE_CYC = TMR_W'(lpdpd_cyc(T_CMDCKE_NS));
  localparam logic [TMR_W-1:0] MRWCKEL_CYC = TMR_W'(lpdpd_cyc(T_MRWCKEL_NS));
  localparam logic [TMR_W-1:0] VREF_LONG_CYC = TMR_W'(lpdpd_cyc(T_VREF_LONG_NS));
  localparam logic [TMR_W-1:0] ZQCKE_CYC = TMR_W'(lpdpd_cyc(T_ZQCKE_NS));
  localparam logic [TMR_W-1:0] RCD_CYC = TMR_W'(lpdpd_cyc(T_RCD_NS));
  localparam logic [TMR_W-1:0] RP_CYC = TMR_W'(lpdpd_cyc(T_RP_NS));
  localparam logic [TMR_W-1:0] RFC_CYC = TMR_W'(lpdpd_cyc(T_RFC_NS));
  localparam logic [TMR_W-1:0] ZQCAL_CYC = TMR_W'(lpdpd_cyc(T_ZQCAL_NS));
  localparam logic [TMR_W-1:0] OSC_CYC = TMR_W'(lpdpd_cyc(T_OSC_NS));
  localparam logic [TMR_W-1:0] RD_PD_CYC =
    TMR_W'(RL_NCK + lpdpd_cyc(T_DQSCK_MAX_NS) + BL / 2 + RD_POST_SHORT_NCK);
  localparam logic [TMR_W-1:0] RD_PD_LONG_CYC =
    TMR_W'(RL_NCK + lpdpd_cyc(T_DQSCK_MAX_NS) + BL / 2 + RD_POST_LONG_NCK);
  localparam logic [TMR_W-1:0] WR_PD_CYC =
    TMR_W'(WL_NCK + lpdpd_cyc(T_DQSS_DQS2DQ_NS) + BL / 2 + lpdpd_cyc(T_WR_NS));
  // "more than" the sum: one cycle on top
  localparam logic [TMR_W-1:0] WRA_PD_CYC =
    TMR_W'(WL_NCK + lpdpd_cyc(T_DQSS_DQS2DQ_NS) + BL / 2 + NWR_NCK + WRA_EXTRA_NCK + 1);

  // ****************************************
  // commands and power-down kinds
  // ****************************************
  typedef enum logic [5:0] {
    CMD_DES, CMD_ACT, CMD_PRE, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA, CMD_MRR,
    CMD_MRW, CMD_MRW_LONG, CMD_REF, CMD_ZQ_START, CMD_OSC_START, CMD_SRE, CMD_SRX
  } lpdpd_cmd_t;
  typedef enum logic [1:0] {PDK_NONE, PDK_IDLE, PDK_ACTIVE, PDK_SELF} lpdpd_pdk_t;
  localparam logic [2:0] TERM_FIELD_OFF = 3'h0;

endpackage

// ### rtl/lpdpd_if.sv
// interface: command-side pins between the controller and the dram power-down logic
`timescale 1ns/1ps
`default_nettype none
interface lpdpd_if;
  logic cke;
  logic cs;
  logic [5:0] ca;
  logic ck_run;
  logic reset_n;
  modport ctl (output cke, output cs, output ca, output ck_run, output reset_n);
  modport dram (input cke, input cs, input ca, input ck_run, input reset_n);
endinterface
`default_nettype wire

// ### rtl/lpdpd_timer.sv
// module: loadable down-counter that keeps the longer of the running and the new wait
`timescale 1ns/1ps
`default_nettype none
module lpdpd_timer
  import lpdpd_pkg::*;
(
  input wire logic clk_in,              // system clock
  input wire logic rst_in,              // async reset, high
  input wire logic load_in,             // start or extend a wait
  input wire logic [TMR_W-1:0] val_in,  // wait length in cycles
  output logic busy_out                 // wait still running
);
  logic [TMR_W-1:0] count;
  wire [TMR_W-1:0] dec_count;
  wire [TMR_W-1:0] next_count;

  // a shorter load never cuts a longer wait already running
  assign dec_count = (count != TMR_ZERO) ? count - TMR_ONE : count;
  assign next_count = (load_in && val_in > dec_count) ? val_in : dec_count;
  assign busy_out = (count != TMR_ZERO);

  // counter register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      count <= TMR_ZERO;
    else
      count <= next_count;
  end
endmodule
`default_nettype wire

// ### rtl/lpdpd_dram.sv
// module: dram end, power-down entry, exit and classification behind the command pins
`timescale 1ns/1ps
`default_nettype none
module lpdpd_dram
  import lpdpd_pkg::*;
(
  input wire logic clk_in,                      // system clock
  input wire logic rst_in,                      // async reset, high
  lpdpd_if.dram pins,                           // command-side pins
  input wire logic [2:0] term_field_in,         // termination enable field
  input wire logic cmd_term_reg_in,             // termination enabled by register
  input wire logic command_termination_pad_in,  // termination enabled by pad
  input wire logic vddq_ok_in,                  // output supply valid
  output logic io_buf_on_out,                   // in/out buffers enabled
  output logic rx_on_out,                       // input receivers enabled
  output lpdpd_pdk_t pd_kind_out,               // power-down kind
  output logic refresh_on_out,                  // refresh executing
  output logic zq_cal_on_out,                   // impedance calibration running
  output logic ca_term_on_out,                  // command bus terminated
  output logic cmd_valid_out,                   // command taken, pulse
  output lpdpd_cmd_t cmd_out                    // command taken
);
  localparam int NP = 2;
  localparam int ND = 4;
  localparam int TD_LCK = 0;
  localparam int TD_RFC = 1;
  localparam int TD_ZQ = 2;
  localparam int TD_ZQCKE = 3;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [NP-1:0] pin_s1;
  logic [NP-1:0] pin_s2;
  logic [NP-1:0] pin_s3;
  logic [NP-1:0] pin_lvl;
  wire [NP-1:0] pin_raw;
  assign pin_raw = {pins.reset_n, pins.cke};

  // level moves once stages two and three agree
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_pin
      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          pin_s1[gp] <= 1'b0;
          pin_s2[gp] <= 1'b0;
          pin_s3[gp] <= 1'b0;
          pin_lvl[gp] <= 1'b0;
        end
        else
        begin
          pin_s1[gp] <= pin_raw[gp];
          pin_s2[gp] <= pin_s1[gp];
          pin_s3[gp] <= pin_s2[gp];
          if (pin_s2[gp] == pin_s3[gp])
            pin_lvl[gp] <= pin_s3[gp];
        end
      end
    end
  endgenerate

  // ****************************************
  // decode and timers
  // ****************************************
  logic in_pd_q;
  logic row_open;
  logic self_ref;
  logic zq_on;
  logic [ND-1:0] td_load;
  logic [ND-1:0] td_busy;
  logic [TMR_W-1:0] td_val [ND];
  wire alive;
  wire in_pd;
  wire pd_enter;
  wire cmd_take;
  wire lpdpd_cmd_t cmd_in;
  wire zq_abort;

  // cke is an async exit: only the sync lag stands between pin and state
  assign alive = pin_lvl[1];
  assign in_pd = alive && !pin_lvl[0]; // R7
  assign pd_enter = in_pd && !in_pd_q;
  assign cmd_in = lpdpd_cmd_t'(pins.ca);
  // every command-side pin but cke and reset is ignored while down
  assign cmd_take = alive && !in_pd && rx_on_out && pins.ck_run && pins.cs; // R4
  // calibration dropped if cke fell too early after its start
  assign zq_abort = pd_enter && td_busy[TD_ZQCKE]; // R19
  assign td_load[TD_LCK] = pd_enter;
  assign td_val[TD_LCK] = CKELCK_CYC;
  assign td_load[TD_RFC] = cmd_take && cmd_in == CMD_REF;
  assign td_val[TD_RFC] = RFC_CYC;
  assign td_load[TD_ZQ] = cmd_take && cmd_in == CMD_ZQ_START;
  assign td_val[TD_ZQ] = ZQCAL_CYC;
  assign td_load[TD_ZQCKE] = td_load[TD_ZQ];
  assign td_val[TD_ZQCKE] = ZQCKE_CYC;

  genvar gt;
  generate
    for (gt = 0; gt < ND; gt++)
    begin : g_tmr
      lpdpd_timer u_tmr (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(td_load[gt]),
        .val_in(td_val[gt]),
        .busy_out(td_busy[gt])
      );
    end
  endgenerate

  // ****************************************
  // state and outputs
  // ****************************************
  // bank and mode state, cleared while the reset pin is low
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      in_pd_q <= 1'b0;
      row_open <= 1'b0;
      self_ref <= 1'b0;
      zq_on <= 1'b0;
    end
    else
    begin
      in_pd_q <= in_pd;
      if (!alive)
      begin
        row_open <= 1'b0;
        self_ref <= 1'b0;
      end
      else if (cmd_take)
      begin
        if (cmd_in == CMD_ACT)
          row_open <= 1'b1;
        else if (cmd_in == CMD_PRE || cmd_in == CMD_RDA || cmd_in == CMD_WRA)
          row_open <= 1'b0;
        if (cmd_in == CMD_SRE)
          self_ref <= 1'b1;
        else if (cmd_in == CMD_SRX)
          self_ref <= 1'b0;
      end
      zq_on <= alive && !zq_abort && (td_load[TD_ZQ] || (zq_on && td_busy[TD_ZQ])); // R19
    end
  end

  // registered outputs
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      io_buf_on_out <= 1'b0;
      rx_on_out <= 1'b0;
      pd_kind_out <= PDK_NONE;
      refresh_on_out <= 1'b0;
      zq_cal_on_out <= 1'b0;
      ca_term_on_out <= 1'b0;
      cmd_valid_out <= 1'b0;
      cmd_out <= CMD_DES;
    end
    else
    begin
      io_buf_on_out <= alive && !in_pd; // R2
      rx_on_out <= alive && (!in_pd || pd_enter || td_busy[TD_LCK]); // R4
      if (!in_pd)
        pd_kind_out <= PDK_NONE;
      else if (self_ref)
        pd_kind_out <= PDK_SELF; // R10
      else if (row_open)
        pd_kind_out <= PDK_ACTIVE; // R10
      else
        pd_kind_out <= PDK_IDLE; // R10
      // only self-refresh power-down keeps refreshing
      refresh_on_out <= alive && (self_ref || (td_busy[TD_RFC] && !in_pd)); // R6
      zq_cal_on_out <= zq_on;
      // termination ignores power-down, needs only a nonzero field, an enable and a valid supply
      ca_term_on_out <= (term_field_in != TERM_FIELD_OFF) &&
        (cmd_term_reg_in || command_termination_pad_in) && vddq_ok_in; // R11
      cmd_valid_out <= cmd_take;
      if (cmd_take)
        cmd_out <= cmd_in;
    end
  end
endmodule
`default_nettype wire

// ### rtl/lpdpd_ctrl.sv
// module: controller end, sequences power-down entry, clock stop, frequency change and exit
`timescale 1ns/1ps
`default_nettype none
// What the controller and dram ends do
// R1: no cke low during reads, writes, mode ops
// R2: dram disables buffers except cke, reset
// R3: cs low, clock running after cke falls
// R4: receivers off after clock-hold time expires
// R5: cke low held at least minimum pulse
// R6: no refresh in power-down except self-refresh
// R7: cke high exits; held high minimum pulse
// R8: first command only after exit latency
// R9: no clock stop/change in guarded windows
// R10: power-down classed idle, active, self-refresh
// R11: command termination stays on when enabled
// R12: no power-down while oscillator measurement runs
// R13: read to cke low minimum delay
// R14: mode read to cke low minimum delay
// R15: write to cke low minimum delay
// R16: auto-precharge write to cke low delay
// R17: activate, precharge hold cke for delay
// R18: mode write hold, longer for slow settings
// R19: calibration continues if started early enough
// R20: frequency change only after row ops settle
// R21: clock held at entry, stable before exit
// R22: clock stop only after row ops settle
// R23: flag mode updates after frequency change
// R24: delays become rounded-up down-counts
module lpdpd_ctrl
  import lpdpd_pkg::*;
(
  input wire logic clk_in,              // system clock
  input wire logic rst_in,              // async reset, high
  lpdpd_if.ctl pins,                    // command-side pins
  input wire logic req_valid_in,        // command request
  input wire lpdpd_cmd_t req_cmd_in,    // command to issue
  output logic req_ready_out,           // command can be taken
  input wire logic rd_post_long_in,     // long read postamble set
  input wire logic pd_req_in,           // want power-down, level
  input wire logic pd_exit_in,          // want exit, level
  input wire logic clk_stop_req_in,     // want clock stopped, level
  input wire logic freq_chg_req_in,     // want frequency change, pulse
  output logic in_pd_out,               // cke is low
  output logic clk_stopped_out,         // clock is stopped
  output logic freq_sel_out,            // selected clock frequency
  output logic mr_update_due_out        // mode writes advised
);
  localparam int NT = 7;
  localparam int TI_ENTRY = 0;
  localparam int TI_ROW = 1;
  localparam int TI_LCK = 2;
  localparam int TI_CKE = 3;
  localparam int TI_STAB = 4;
  localparam int TI_XP = 5;
  localparam int TI_OSC = 6;

  typedef enum logic [2:0] {ST_RUN, ST_SETTLE, ST_PD, ST_WAKE, ST_EXIT} lpdpd_st_t;

  // ****************************************
  // decode
  // ****************************************
  lpdpd_st_t st;
  lpdpd_st_t next_st;
  logic [NT-1:0] tm_load;
  logic [NT-1:0] tm_busy;
  logic [TMR_W-1:0] tm_val [NT];
  wire take;
  wire is_rd;
  wire pd_go;
  wire stop_ok;
  wire chg_ok;
  wire wake_go;
  wire rise_go;
  wire exit_done;
  wire boot_rise;
  wire [TMR_W-1:0] entry_gap;

  assign take = req_valid_in && req_ready_out;
  assign is_rd = req_cmd_in == CMD_RD || req_cmd_in == CMD_RDA || req_cmd_in == CMD_MRR;

  // least gap from each command to cke falling; zero for the rest
  assign entry_gap =
    is_rd ? (rd_post_long_in ? RD_PD_LONG_CYC : RD_PD_CYC) : // R13 R14
    (req_cmd_in == CMD_WR) ? WR_PD_CYC : // R15
    (req_cmd_in == CMD_WRA) ? WRA_PD_CYC : // R16
    (req_cmd_in == CMD_ACT || req_cmd_in == CMD_PRE || req_cmd_in == CMD_REF) ? CMDCKE_CYC : // R17
    (req_cmd_in == CMD_MRW) ? MRWCKEL_CYC : // R18
    (req_cmd_in == CMD_MRW_LONG) ? VREF_LONG_CYC : // R18 R1
    (req_cmd_in == CMD_ZQ_START) ? ZQCKE_CYC : TMR_ZERO; // R19

  // entry waits out every guard, oscillator run and minimum high time
  assign pd_go = st == ST_RUN && pd_req_in && !take && !tm_busy[TI_ENTRY] &&
    !tm_busy[TI_OSC] && !tm_busy[TI_CKE]; // R1 R12 R7 R9
  // clock may move only once settled down and row ops done; an exit beats a stop,
  // so cke never rises on a dead clock
  assign stop_ok = st == ST_PD && clk_stop_req_in && !clk_stopped_out && !wake_go &&
    !tm_busy[TI_ROW] && !tm_busy[TI_LCK]; // R22 R9
  assign chg_ok = st == ST_PD && freq_chg_req_in && !clk_stopped_out &&
    !tm_busy[TI_ROW] && !tm_busy[TI_LCK]; // R20 R9
  assign wake_go = st == ST_PD && pd_exit_in && !tm_busy[TI_CKE]; // R5
  assign rise_go = st == ST_WAKE && !tm_busy[TI_STAB]; // R21
  // the first raise after reset runs the same exit waits as a wake-up
  assign boot_rise = st == ST_EXIT && !pins.cke; // R8
  assign exit_done = st == ST_EXIT && pins.cke && !tm_busy[TI_XP] && !tm_busy[TI_CKE]; // R8 R7

  // ****************************************
  // wait timers
  // ****************************************
  // each wait is a rounded-up count run down to zero
  assign tm_load[TI_ENTRY] = take; // R24
  assign tm_val[TI_ENTRY] = entry_gap;
  assign tm_load[TI_ROW] = take && (req_cmd_in == CMD_ACT || req_cmd_in == CMD_PRE);
  assign tm_val[TI_ROW] = (req_cmd_in == CMD_ACT) ? RCD_CYC : RP_CYC;
  assign tm_load[TI_LCK] = pd_go; // R3 R21
  assign tm_val[TI_LCK] = CKELCK_CYC;
  assign tm_load[TI_CKE] = pd_go || rise_go || boot_rise; // R5 R7
  assign tm_val[TI_CKE] = CKE_MIN_CYC;
  assign tm_load[TI_STAB] = wake_go; // R21
  assign tm_val[TI_STAB] = CKCKEH_CYC;
  assign tm_load[TI_XP] = rise_go || boot_rise; // R8
  assign tm_val[TI_XP] = XP_CYC;
  assign tm_load[TI_OSC] = take && req_cmd_in == CMD_OSC_START; // R12
  assign tm_val[TI_OSC] = OSC_CYC;

  genvar gt;
  generate
    for (gt = 0; gt < NT; gt++)
    begin : g_tmr
      lpdpd_timer u_tmr (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(tm_load[gt]),
        .val_in(tm_val[gt]),
        .busy_out(tm_busy[gt])
      );
    end
  endgenerate

  // ****************************************
  // sequencer
  // ****************************************
  // next state
  always_comb
  begin
    next_st = st;
    unique case (st)
      ST_RUN:
        if (pd_go)
          next_st = ST_SETTLE;
      ST_SETTLE:
        if (!tm_busy[TI_LCK])
          next_st = ST_PD;
      ST_PD:
        if (wake_go)
          next_st = ST_WAKE;
      ST_WAKE:
        if (rise_go)
          next_st = ST_EXIT;
      ST_EXIT:
        if (exit_done)
          next_st = ST_RUN;
    endcase
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      st <= ST_EXIT;
    else
      st <= next_st;
  end

  // pins: cs stays low all through power-down, ca is don't care
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pins.cke <= 1'b0;
      pins.cs <= 1'b0;
      pins.ca <= 6'h00;
      pins.ck_run <= 1'b1;
      pins.reset_n <= 1'b0;
    end
    else
    begin
      pins.reset_n <= 1'b1;
      pins.cs <= take; // R3
      pins.ca <= take ? req_cmd_in : CMD_DES;
      if (pd_go)
        pins.cke <= 1'b0; // R1
      else if (rise_go || boot_rise)
        pins.cke <= 1'b1; // R7
      if (stop_ok)
        pins.ck_run <= 1'b0; // R22
      else if (wake_go)
        pins.ck_run <= 1'b1; // R21
    end
  end

  // user-side status
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      req_ready_out <= 1'b0;
      in_pd_out <= 1'b0;
      clk_stopped_out <= 1'b0;
      freq_sel_out <= 1'b0;
      mr_update_due_out <= 1'b0;
    end
    else
    begin
      // a request never lands in the cycle cke falls
      req_ready_out <= next_st == ST_RUN && !pd_go; // R8
      in_pd_out <= next_st != ST_RUN && next_st != ST_EXIT;
      if (stop_ok)
        clk_stopped_out <= 1'b1;
      else if (wake_go)
        clk_stopped_out <= 1'b0;
      if (chg_ok)
        freq_sel_out <= !freq_sel_out; // R20
      // set wins over the clearing mode write
      if (chg_ok)
        mr_update_due_out <= 1'b1; // R23
      else if (take && (req_cmd_in == CMD_MRW || req_cmd_in == CMD_MRW_LONG))
        mr_update_due_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### tb/lpdpd_checker.sv
// checker: wire rules between the controller and dram ends
`timescale 1ns/1ps
`default_nettype none
module lpdpd_checker
  import lpdpd_pkg::*;
(
  input wire logic clk_in,    // system clock
  input wire logic rst_in,    // async reset, high
  input wire logic cke,       // clock enable
  input wire logic cs,        // command strobe
  input wire logic [5:0] ca,  // command code
  input wire logic ck_run,    // clock present
  input wire logic reset_n    // dram reset, low
);
  logic [TMR_W-1:0] guard;
  logic [TMR_W-1:0] need;
  // least wait per command; short postamble is the safe lower bound
  assign need = (ca == CMD_RD || ca == CMD_RDA || ca == CMD_MRR) ? RD_PD_CYC :
    (ca == CMD_WR) ? WR_PD_CYC : (ca == CMD_WRA) ? WRA_PD_CYC : (ca == CMD_MRW) ? MRWCKEL_CYC :
    (ca == CMD_MRW_LONG) ? VREF_LONG_CYC : (ca == CMD_OSC_START) ? OSC_CYC : CMDCKE_CYC;
  // remaining entry wait, the longest command wins
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      guard <= TMR_ZERO;
    else if (cs && need > guard)
      guard <= need;
    else if (guard != TMR_ZERO)
      guard <= guard - TMR_ONE;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_hold_clk;
    ck_run [*2];
  endsequence
  sequence s_exit_quiet;
    (cke && !cs) [*5];
  endsequence
  cs_quiet_pd_a: assert property (!cke |-> !cs) else $error("strobe high while cke low");
  hold_clk_a: assert property ($fell(cke) |-> s_hold_clk) else $error("clock lost at entry");
  stable_clk_a: assert property ($rose(cke) |-> $past(ck_run)) else $error("clock not stable at exit");
  exit_quiet_a: assert property ($rose(cke) |-> s_exit_quiet) else $error("command inside exit latency");
  entry_guard_a: assert property ($fell(cke) |-> guard <= TMR_ONE) else $error("cke fell too soon");
  stop_late_a: assert property ($fell(ck_run) |-> !cke && !$past(cke) && !$past(cke, 2)) else $error("early stop");
  run_awake_a: assert property (cke |-> ck_run) else $error("clock stopped with cke high");
  cmd_awake_a: assert property (cs |-> cke && reset_n) else $error("command while asleep");
  low_hold_a: assert property ($fell(cke) |=> !cke [*2]) else $error("cke low pulse short");
endmodule
`default_nettype wire

// ### tb/lpdram_power_down_control_test.sv
// testbench: both ends joined, entry delays, exit, clock stop and dram status
`timescale 1ns/1ps
`default_nettype none
module lpdram_power_down_control_test
  import lpdpd_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid = 1'b0, rd_long = 1'b0, pd_req = 1'b0, pd_exit = 1'b0, stop_req = 1'b0, freq_req = 1'b0;
  lpdpd_cmd_t req_cmd = CMD_DES;
  logic [2:0] term_field = 3'h0;
  logic term_reg = 1'b0, term_pad = 1'b0, vddq_ok = 1'b1;
  logic ready, in_pd, stopped, freq_sel, mr_due, io_buf, rx_on, ref_on, zq_on, term_on, cmd_vld;
  lpdpd_pdk_t pd_kind;
  lpdpd_cmd_t cmd_seen;
  int n_fail = 0;
  int checks_done = 0;
  // command table: entry wait and expected kind; last entry uses long postamble
  lpdpd_cmd_t cmds [14] = '{CMD_ACT, CMD_RD, CMD_WR, CMD_MRR, CMD_MRW, CMD_MRW_LONG, CMD_ZQ_START,
    CMD_OSC_START, CMD_REF, CMD_RDA, CMD_ACT, CMD_WRA, CMD_PRE, CMD_RD};
  logic [TMR_W-1:0] needs [14] = '{CMDCKE_CYC, RD_PD_CYC, WR_PD_CYC, RD_PD_CYC, MRWCKEL_CYC, VREF_LONG_CYC,
    ZQCKE_CYC, OSC_CYC, CMDCKE_CYC, RD_PD_CYC, CMDCKE_CYC, WRA_PD_CYC, CMDCKE_CYC, RD_PD_LONG_CYC};
  lpdpd_pdk_t kinds [14] = '{PDK_ACTIVE, PDK_ACTIVE, PDK_ACTIVE, PDK_ACTIVE, PDK_ACTIVE, PDK_ACTIVE,
    PDK_ACTIVE, PDK_ACTIVE, PDK_ACTIVE, PDK_IDLE, PDK_ACTIVE, PDK_IDLE, PDK_IDLE, PDK_IDLE};
  // termination cases: field, reg, pad, supply
  logic [5:0] tvec [4] = '{6'h0B, 6'h07, 6'h25, 6'h1E};
  logic [3:0] texp = 4'h5;
  always #50 clk_in = ~clk_in;
  lpdpd_if i_lpdpd_if ();
  lpdpd_ctrl i_lpdpd_ctrl (.clk_in(clk_in), .rst_in(rst_in), .pins(i_lpdpd_if), .req_valid_in(req_valid),
    .req_cmd_in(req_cmd), .req_ready_out(ready), .rd_post_long_in(rd_long), .pd_req_in(pd_req),
    .pd_exit_in(pd_exit), .clk_stop_req_in(stop_req), .freq_chg_req_in(freq_req), .in_pd_out(in_pd),
    .clk_stopped_out(stopped), .freq_sel_out(freq_sel), .mr_update_due_out(mr_due));
  lpdpd_dram i_lpdpd_dram (.clk_in(clk_in), .rst_in(rst_in), .pins(i_lpdpd_if), .term_field_in(term_field),
    .cmd_term_reg_in(term_reg), .command_termination_pad_in(term_pad), .vddq_ok_in(vddq_ok),
    .io_buf_on_out(io_buf), .rx_on_out(rx_on), .pd_kind_out(pd_kind), .refresh_on_out(ref_on),
    .zq_cal_on_out(zq_on), .ca_term_on_out(term_on), .cmd_valid_out(cmd_vld), .cmd_out(cmd_seen));
  lpdpd_checker i_lpdpd_checker (.clk_in(clk_in), .rst_in(rst_in), .cke(i_lpdpd_if.cke), .cs(i_lpdpd_if.cs),
    .ca(i_lpdpd_if.ca), .ck_run(i_lpdpd_if.ck_run), .reset_n(i_lpdpd_if.reset_n));
  task automatic end_sim();
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // bounded wait on ready (sel 0) or cke (sel 1); a timeout ends the run
  task automatic wait_sig(input int sel, input logic lvl, output int k);
    k = 0;
    while (((sel == 0) ? ready : i_lpdpd_if.cke) !== lvl && k < 200)
    begin
      tick(1);
      k++;
    end
    if (k == 200)
    begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic issue(input lpdpd_cmd_t c);
    int k;
    wait_sig(0, 1'b1, k);
    req_valid = 1'b1;
    req_cmd = c;
    tick(1);
    req_valid = 1'b0;
    chk({i_lpdpd_if.cs, i_lpdpd_if.ca}, {1'b1, c});
  endtask
  // sleep as soon as allowed; k counts cycles from the command
  task automatic enter_pd(output int k);
    pd_req = 1'b1;
    wait_sig(1, 1'b0, k);
    pd_req = 1'b0;
    tick(8);
  endtask
  task automatic leave_pd();
    int k;
    pd_exit = 1'b1;
    wait_sig(1, 1'b1, k);
    pd_exit = 1'b0;
    chk({i_lpdpd_if.ck_run, ready, in_pd}, 3'h4);
  endtask
  initial
  begin
    int k;
    tick(10);
    rst_in = 1'b0;
    wait_sig(0, 1'b1, k);
    tick(2);
    chk({io_buf, rx_on, pd_kind}, {2'h3, PDK_NONE});
    // clock stop and frequency change must be ignored while awake
    stop_req = 1'b1;
    freq_req = 1'b1;
    tick(1);
    freq_req = 1'b0;
    tick(2);
    chk({stopped, i_lpdpd_if.ck_run, freq_sel}, 3'h2);
    stop_req = 1'b0;
    for (int i = 0; i < 14; i++)
    begin
      rd_long = (i == 13);
      issue(cmds[i]);
      enter_pd(k);
      chk(k >= needs[i], 1'b1);
      chk({io_buf, rx_on, ref_on, in_pd}, 4'h1);
      chk(zq_on, i == 6);
      chk(pd_kind, kinds[i]);
      chk(cmd_seen, cmds[i]);
      leave_pd();
    end
    // self-refresh sleep keeps refreshing; change frequency, stop the clock
    issue(CMD_SRE);
    enter_pd(k);
    chk({pd_kind, ref_on}, {PDK_SELF, 1'b1});
    for (int j = 0; j < 4; j++)
    begin
      {term_field, term_reg, term_pad, vddq_ok} = tvec[j];
      tick(3);
      chk(term_on, texp[j]);
    end
    vddq_ok = 1'b1;
    freq_req = 1'b1;
    tick(1);
    freq_req = 1'b0;
    stop_req = 1'b1;
    tick(2);
    chk({freq_sel, mr_due, stopped, i_lpdpd_if.ck_run}, 4'hE);
    stop_req = 1'b0;
    leave_pd();
    issue(CMD_SRX);
    tick(1);
    chk({cmd_vld, cmd_seen}, {1'b1, CMD_SRX});
    issue(CMD_MRW);
    tick(2);
    chk(mr_due, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
